// ==== src/tpcs_defs.svh ====
// addresses, field ranges, reset values and timing figures of the
// trim page overlay and engine setup block; included by the trim rom, top and test files
`ifndef TPCS_DEFS_SVH
`define TPCS_DEFS_SVH

// i/o ram control bytes
`define TPCS_IO_MUX 16'h2100
`define TPCS_IO_EQN 16'h2106
`define TPCS_IO_ACC_HI 16'h2107
`define TPCS_IO_ACC_LO 16'h2108
`define TPCS_IO_LOC 16'h2109
`define TPCS_IO_DIFF 16'h210c
`define TPCS_IO_RMT 16'h2709
`define TPCS_IO_TRIM 16'h270b

// field ranges inside those bytes
`define TPCS_MUX_F 7:4
`define TPCS_EQN_F 7:5
`define TPCS_EN_B 0
`define TPCS_ACC_HI_F 4:0
`define TPCS_FIR_F 2:1
`define TPCS_TRIM_B 0

// reset values and location write masks
`define TPCS_MUX_RST 4'h7
`define TPCS_FIR_RST 8'h02
`define TPCS_EQN_RST 3'h5
`define TPCS_ACC_RST 13'h0888
`define TPCS_LOC_MASK_L 7'h7f
`define TPCS_LOC_MASK_S 7'h3f

// trim page offsets inside the 1KB page
`define TPCS_OFF_TEMP_HI 10'h090
`define TPCS_OFF_TEMP_LO 10'h091
`define TPCS_OFF_VHOT_HI 10'h092
`define TPCS_OFF_VHOT_LO 10'h093
`define TPCS_OFF_VROOM 10'h094
`define TPCS_OFF_DISP_HI 10'h095
`define TPCS_OFF_DISP_ZERO 10'h096

// page base is the code location times 1024
`define TPCS_PAGE_SHIFT 10
// conversion cycles times conversions per frame, 2 times 7 at reset
`define TPCS_FRAME_CONV 8'h0e

`endif

// ==== src/tpcs_pkg.sv ====
// types shared by the trim page and engine setup design files
package tpcs_pkg;

    typedef logic [7:0] tpcs_byte_t;

    typedef enum logic [2:0] {
        TPCS_EQ_AB = 3'h2,
        TPCS_EQ_DELTA = 3'h3,
        TPCS_EQ_WYE2 = 3'h4,
        TPCS_EQ_WYE3 = 3'h5
    } tpcs_eqn_t;

    typedef enum logic {
        TPCS_ACC_IDLE,
        TPCS_ACC_RUN
    } tpcs_acc_state_t;

endpackage : tpcs_pkg

// ==== src/tpcs_trim_rom.sv ====
// read-only trim fuse page; one registered byte per read
// assumes the caller decodes page hits and feeds the in-page offset
`timescale 1ns/100ps
`include "tpcs_defs.svh"
module tpcs_trim_rom #(
    parameter logic [10:0] TEMP_HOT = 11'h000,
    parameter logic [15:0] VREF_HOT = 16'h0000,
    parameter logic [7:0] VREF_ROOM = 8'h00,
    parameter logic [7:0] DISP_HIGH = 8'h00,
    parameter logic [7:0] DISP_ZERO = 8'h00
) (
    // clock
    input wire logic clk_in,
    // read port
    input wire logic rd_in,
    input wire logic [9:0] off_in,
    output tpcs_pkg::tpcs_byte_t rdata_out
);
    import tpcs_pkg::*;

    tpcs_byte_t rdata_ff;
    tpcs_byte_t nxt_rdata;

    // no write path exists: the fuse bytes can never be altered
    always_comb begin
        case (off_in)
            `TPCS_OFF_TEMP_HI: nxt_rdata = {5'h00, TEMP_HOT[10:8]};
            `TPCS_OFF_TEMP_LO: nxt_rdata = TEMP_HOT[7:0];
            `TPCS_OFF_VHOT_HI: nxt_rdata = VREF_HOT[15:8];
            `TPCS_OFF_VHOT_LO: nxt_rdata = VREF_HOT[7:0];
            `TPCS_OFF_VROOM: nxt_rdata = VREF_ROOM;
            `TPCS_OFF_DISP_HI: nxt_rdata = DISP_HIGH;
            `TPCS_OFF_DISP_ZERO: nxt_rdata = DISP_ZERO;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rd_in) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata_out = rdata_ff;

endmodule : tpcs_trim_rom

// ==== src/tpcs_engine_ram.sv ====
// engine data memory: 32-bit words, byte port for the processor
// and a word port for the engine; both reads are registered
`timescale 1ns/100ps
module tpcs_engine_ram #(
    parameter int AW = 8
) (
    // clock
    input wire logic clk_in,
    // processor byte port
    input wire logic [AW+1:0] pb_addr_in,
    input wire logic pb_wr_in,
    input wire logic pb_rd_in,
    input wire logic [7:0] pb_wdata_in,
    output logic [7:0] pb_rdata_out,
    // engine word port
    input wire logic [AW-1:0] ew_addr_in,
    output logic [31:0] ew_rdata_out
);
    logic [31:0] mem_ff [2**AW];
    logic [7:0] pb_rdata_ff;
    logic [31:0] ew_rdata_ff;
    logic [AW-1:0] pb_word;
    logic [4:0] pb_shift;

    // big-endian: byte offset 0 is the top lane, offset 3 the bottom
    assign pb_word = pb_addr_in[AW+1:2];
    assign pb_shift = {~pb_addr_in[1:0], 3'h0};

    // every word is four bytes, read whole as two's complement
    always_ff @(posedge clk_in) begin
        if (pb_wr_in) begin
            mem_ff[pb_word][pb_shift +: 8] <= pb_wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (pb_rd_in) begin
            pb_rdata_ff <= mem_ff[pb_word][pb_shift +: 8];
        end
        ew_rdata_ff <= mem_ff[ew_addr_in];
    end

    assign pb_rdata_out = pb_rdata_ff;
    assign ew_rdata_out = ew_rdata_ff;

endmodule : tpcs_engine_ram

// ==== src/tpcs_top.sv ====
// trim page overlay on program space, engine data memory byte map,
// and the engine setup fields held in i/o ram
// assumes processor strobes are synchronous to clk_in and last one cycle
`timescale 1ns/100ps
`include "tpcs_defs.svh"

module tpcs_top #(
    parameter int LARGE_FLASH = 0,
    parameter int ENG_AW = 8,
    // fuse contents: arbitrary neutral values
    parameter logic [10:0] TEMP_HOT = 11'h000,
    parameter logic [15:0] VREF_HOT = 16'h0000,
    parameter logic [7:0] VREF_ROOM = 8'h00,
    parameter logic [7:0] DISP_HIGH = 8'h00,
    parameter logic [7:0] DISP_ZERO = 8'h00
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // processor data space
    input wire logic [15:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_wdata_in,
    output tpcs_pkg::tpcs_byte_t io_rdata_out,
    // processor program space
    input wire logic [16:0] prog_addr_in,
    input wire logic prog_rd_in,
    input wire logic [7:0] flash_rdata_in,
    output tpcs_pkg::tpcs_byte_t prog_rdata_out,
    output logic prog_rvalid_out,
    // engine side
    input wire logic [ENG_AW-1:0] eng_word_addr_in,
    output logic [31:0] eng_rdata_out,
    input wire logic sample_strobe_in,
    output logic accum_done_out,
    // setup fields
    output logic engine_enable_out,
    output tpcs_pkg::tpcs_eqn_t equation_select_out,
    output logic equation_valid_out,
    output logic [2:0] element_mask_out,
    output logic current_diff_out,
    output logic [12:0] accumulation_count_out,
    output logic [3:0] mux_divider_out,
    output logic [1:0] filter_length_out,
    output logic timing_ok_out,
    output tpcs_pkg::tpcs_byte_t differential_enable_out,
    output tpcs_pkg::tpcs_byte_t remote_sensor_enable_out,
    output logic [6:0] engine_code_location_out,
    output logic trim_page_select_out
);
    import tpcs_pkg::*;

    if (LARGE_FLASH < 0 || LARGE_FLASH > 1) begin : g_bad_variant
        $error("LARGE_FLASH must be 0 or 1");
    end
    if (ENG_AW < 1 || ENG_AW > 11) begin : g_bad_aw
        $error("engine memory must fit below the i/o ram window");
    end

    localparam logic [6:0] LOC_MASK =
        (LARGE_FLASH == 1) ? `TPCS_LOC_MASK_L : `TPCS_LOC_MASK_S;

    logic [3:0] mux_ff;
    logic [7:0] eqn_byte_ff;
    logic [12:0] acc_ff;
    logic [6:0] loc_ff;
    tpcs_byte_t diff_ff;
    tpcs_byte_t rmt_ff;
    logic trim_sel_ff;
    tpcs_byte_t io_rdata_ff;
    tpcs_byte_t nxt_io_rdata;
    logic ram_sel_ff;
    logic in_ram;
    tpcs_byte_t ram_byte;
    tpcs_byte_t trim_byte;
    tpcs_byte_t flash_ff;
    logic hit_ff;
    logic page_hit;
    logic rvalid_ff;
    logic [12:0] acc_cnt_ff;
    logic [12:0] nxt_acc_cnt;
    tpcs_acc_state_t acc_state_ff;
    tpcs_acc_state_t nxt_acc_state;
    logic done_ff;
    logic nxt_done;
    logic [3:0] conv_cycles;

    // engine memory lives at the bottom of the processor data space
    assign in_ram = (io_addr_in[15:ENG_AW+2] == '0);

    // configuration writes; writes during reset are ignored
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            mux_ff <= `TPCS_MUX_RST;
            eqn_byte_ff <= {`TPCS_EQN_RST, 5'h00};
            acc_ff <= `TPCS_ACC_RST;
            loc_ff <= 7'h00;
            diff_ff <= `TPCS_FIR_RST;
            rmt_ff <= 8'h00;
            trim_sel_ff <= 1'b0;
        end else if (io_wr_in) begin
            case (io_addr_in)
                `TPCS_IO_MUX: mux_ff <= io_wdata_in[`TPCS_MUX_F];
                `TPCS_IO_EQN: eqn_byte_ff <= io_wdata_in;
                `TPCS_IO_ACC_HI: acc_ff[12:8] <= io_wdata_in[`TPCS_ACC_HI_F];
                `TPCS_IO_ACC_LO: acc_ff[7:0] <= io_wdata_in;
                `TPCS_IO_LOC: loc_ff <= io_wdata_in[6:0] & LOC_MASK;
                `TPCS_IO_DIFF: diff_ff <= io_wdata_in;
                `TPCS_IO_RMT: rmt_ff <= io_wdata_in;
                `TPCS_IO_TRIM: trim_sel_ff <= io_wdata_in[`TPCS_TRIM_B];
                default: ;
            endcase
        end
    end

    // register read-back; unmapped bytes read zero
    always_comb begin
        nxt_io_rdata = 8'h00;
        case (io_addr_in)
            `TPCS_IO_MUX: nxt_io_rdata = {mux_ff, 4'h0};
            `TPCS_IO_EQN: nxt_io_rdata = eqn_byte_ff;
            `TPCS_IO_ACC_HI: nxt_io_rdata = {3'h0, acc_ff[12:8]};
            `TPCS_IO_ACC_LO: nxt_io_rdata = acc_ff[7:0];
            `TPCS_IO_LOC: nxt_io_rdata = {1'b0, loc_ff};
            `TPCS_IO_DIFF: nxt_io_rdata = diff_ff;
            `TPCS_IO_RMT: nxt_io_rdata = rmt_ff;
            `TPCS_IO_TRIM: nxt_io_rdata = {7'h00, trim_sel_ff};
            default: nxt_io_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            io_rdata_ff <= 8'h00;
            ram_sel_ff <= 1'b0;
        end else if (io_rd_in) begin
            io_rdata_ff <= nxt_io_rdata;
            ram_sel_ff <= in_ram;
        end
    end

    assign io_rdata_out = ram_sel_ff ? ram_byte : io_rdata_ff;

    tpcs_engine_ram #(
        .AW(ENG_AW)
    ) u_ram (
        .clk_in(clk_in),
        .pb_addr_in(io_addr_in[ENG_AW+1:0]),
        .pb_wr_in(io_wr_in && in_ram && reset_n_in),
        .pb_rd_in(io_rd_in && in_ram),
        .pb_wdata_in(io_wdata_in),
        .pb_rdata_out(ram_byte),
        .ew_addr_in(eng_word_addr_in),
        .ew_rdata_out(eng_rdata_out)
    );

    // overlay covers the whole 1KB page at location times 1024
    assign page_hit = trim_sel_ff &&
        (prog_addr_in[16:`TPCS_PAGE_SHIFT] == loc_ff);

    tpcs_trim_rom #(
        .TEMP_HOT(TEMP_HOT),
        .VREF_HOT(VREF_HOT),
        .VREF_ROOM(VREF_ROOM),
        .DISP_HIGH(DISP_HIGH),
        .DISP_ZERO(DISP_ZERO)
    ) u_rom (
        .clk_in(clk_in),
        .rd_in(prog_rd_in && page_hit),
        .off_in(prog_addr_in[`TPCS_PAGE_SHIFT-1:0]),
        .rdata_out(trim_byte)
    );

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            flash_ff <= 8'h00;
            hit_ff <= 1'b0;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= prog_rd_in;
            if (prog_rd_in) begin
                flash_ff <= flash_rdata_in;
                hit_ff <= page_hit;
            end
        end
    end

    // flash passes through untouched whenever the overlay is off
    assign prog_rdata_out = hit_ff ? trim_byte : flash_ff;
    assign prog_rvalid_out = rvalid_ff;

    // accumulation interval: count samples, pulse at the programmed count
    always_comb begin
        nxt_acc_state = acc_state_ff;
        nxt_acc_cnt = acc_cnt_ff;
        nxt_done = 1'b0;
        case (acc_state_ff)
            TPCS_ACC_IDLE: begin
                nxt_acc_cnt = 13'h0000;
                if (eqn_byte_ff[`TPCS_EN_B] && acc_ff != 13'h0000) begin
                    nxt_acc_state = TPCS_ACC_RUN;
                end
            end
            TPCS_ACC_RUN: begin
                if (!eqn_byte_ff[`TPCS_EN_B] || acc_ff == 13'h0000) begin
                    nxt_acc_state = TPCS_ACC_IDLE;
                end else if (sample_strobe_in) begin
                    if (acc_cnt_ff >= acc_ff - 13'h0001) begin
                        nxt_acc_cnt = 13'h0000;
                        nxt_done = 1'b1;
                    end else begin
                        nxt_acc_cnt = acc_cnt_ff + 13'h0001;
                    end
                end
            end
            default: nxt_acc_state = TPCS_ACC_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            acc_state_ff <= TPCS_ACC_IDLE;
            acc_cnt_ff <= 13'h0000;
            done_ff <= 1'b0;
        end else begin
            acc_state_ff <= nxt_acc_state;
            acc_cnt_ff <= nxt_acc_cnt;
            done_ff <= nxt_done;
        end
    end

    // equation decode: phases used and whether currents are differenced
    always_comb begin
        equation_valid_out = 1'b1;
        element_mask_out = 3'h0;
        current_diff_out = 1'b0;
        case (eqn_byte_ff[`TPCS_EQN_F])
            TPCS_EQ_AB: element_mask_out = 3'h3;
            TPCS_EQ_DELTA: begin
                element_mask_out = 3'h5;
                current_diff_out = 1'b1;
            end
            TPCS_EQ_WYE2: begin
                element_mask_out = 3'h3;
                current_diff_out = 1'b1;
            end
            TPCS_EQ_WYE3: element_mask_out = 3'h7;
            default: equation_valid_out = 1'b0;
        endcase
    end

    // frame budget check; filter code n taken as n+1 cycles per conversion
    assign conv_cycles = {2'h0, diff_ff[`TPCS_FIR_F]} + 4'h1;
    assign timing_ok_out = ((conv_cycles * mux_ff) == `TPCS_FRAME_CONV);

    assign accum_done_out = done_ff;
    assign engine_enable_out = eqn_byte_ff[`TPCS_EN_B];
    assign equation_select_out = tpcs_eqn_t'(eqn_byte_ff[`TPCS_EQN_F]);
    assign accumulation_count_out = acc_ff;
    assign mux_divider_out = mux_ff;
    assign filter_length_out = diff_ff[`TPCS_FIR_F];
    assign differential_enable_out = diff_ff;
    assign remote_sensor_enable_out = rmt_ff;
    assign engine_code_location_out = loc_ff;
    assign trim_page_select_out = trim_sel_ff;

    sequence s_trim_rd(logic [9:0] off);
        prog_rd_in && page_hit && prog_addr_in[9:0] == off;
    endsequence

    sequence s_msb_write;
        io_wr_in && in_ram && io_addr_in[1:0] == 2'h0;
    endsequence

    chk_trim_temp_hi: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_trim_rd(`TPCS_OFF_TEMP_HI) |=> prog_rdata_out == {5'h00, TEMP_HOT[10:8]})
        else $error("temperature high byte wrong");
    chk_trim_vhot: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_trim_rd(`TPCS_OFF_VHOT_HI) |=> prog_rdata_out == VREF_HOT[15:8])
        else $error("hot reference high byte wrong");
    chk_trim_vroom: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_trim_rd(`TPCS_OFF_VROOM) |=> prog_rdata_out == VREF_ROOM)
        else $error("room reference byte wrong");
    chk_trim_disp: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_trim_rd(`TPCS_OFF_DISP_ZERO) |=> prog_rdata_out == DISP_ZERO)
        else $error("display zero-code byte wrong");
    chk_flash_pass: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        prog_rd_in && (!trim_sel_ff || prog_addr_in[16:10] != loc_ff)
        |=> prog_rvalid_out && prog_rdata_out == $past(flash_rdata_in))
        else $error("flash read not passed through");
    chk_page_base: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        page_hit |-> prog_addr_in[16:`TPCS_PAGE_SHIFT] == loc_ff &&
            (LARGE_FLASH == 1 || !prog_addr_in[16]))
        else $error("overlay base outside the location field range");
    chk_ram_bigend: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_msb_write ##1 (!io_wr_in &&
            eng_word_addr_in == $past(io_addr_in[ENG_AW+1:2]))
        |=> eng_rdata_out[31:24] == $past(io_wdata_in, 2))
        else $error("engine word not big-endian");
    chk_acc_interval: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        accum_done_out |-> $past(sample_strobe_in) &&
            $past(acc_cnt_ff) == $past(acc_ff) - 13'h0001)
        else $error("accumulation interval length wrong");
    chk_reset_timing: assert property (@(posedge clk_in)
        $rose(reset_n_in) |-> filter_length_out == 2'h1 &&
            mux_divider_out == 4'h7 && timing_ok_out)
        else $error("default frame timing wrong");
    chk_equ_three: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        equation_select_out == TPCS_EQ_WYE3 |->
            element_mask_out == 3'h7 && !current_diff_out && equation_valid_out)
        else $error("three element decode wrong");

endmodule : tpcs_top

// ==== verification/tpcs_flash_model.sv ====
// program flash stand-in seen behind the trim page overlay
// assumes a combinational byte per address, valid with the fetch strobe
`timescale 1ns/100ps
module tpcs_flash_model (
    // fetch address
    input wire logic [16:0] addr_in,
    // flash byte
    output logic [7:0] rdata_out
);
    // address-derived pattern, so an overlaid or stale byte stands out
    assign rdata_out = addr_in[7:0] ^ addr_in[15:8] ^ {7'h0, addr_in[16]}
        ^ 8'h3c;
endmodule : tpcs_flash_model

// ==== verification/tpcs_top_test.sv ====
// self-checking bench for the trim overlay and engine setup block
// assumes tpcs_top with a 6-bit location field and a flash model
`timescale 1ns/100ps
`include "tpcs_defs.svh"
module tpcs_top_test;
    import tpcs_pkg::*;
    localparam logic [10:0] T_HOT = 11'h5a3;
    localparam logic [15:0] V_HOT = 16'hbeef;
    logic clk_in, reset_n_in, io_wr_in, io_rd_in, prog_rd_in;
    logic sample_strobe_in, prog_rvalid_out, accum_done_out;
    logic [15:0] io_addr_in;
    logic [7:0] io_wdata_in, flash_rdata_in, rd;
    logic [16:0] prog_addr_in;
    logic [7:0] eng_word_addr_in;
    logic [31:0] eng_rdata_out;
    tpcs_byte_t io_rdata_out, prog_rdata_out, diff_out, rmt_out;
    tpcs_eqn_t eqn_out;
    logic en_out, valid_out, cdiff_out, timing_ok_out, trim_out;
    logic [2:0] mask_out;
    logic [12:0] acc_out;
    logic [3:0] mux_out;
    logic [1:0] fir_out;
    logic [6:0] loc_out;
    logic [7:0] tb [7];
    logic [7:0] got [7];
    int mismatches, n_checks;

    tpcs_top #(.LARGE_FLASH(0), .ENG_AW(8), .TEMP_HOT(T_HOT),
        .VREF_HOT(V_HOT), .VREF_ROOM(8'hc4), .DISP_HIGH(8'h81),
        .DISP_ZERO(8'h7e)) dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in),
        .io_addr_in(io_addr_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
        .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
        .prog_addr_in(prog_addr_in), .prog_rd_in(prog_rd_in),
        .flash_rdata_in(flash_rdata_in), .prog_rdata_out(prog_rdata_out),
        .prog_rvalid_out(prog_rvalid_out),
        .eng_word_addr_in(eng_word_addr_in), .eng_rdata_out(eng_rdata_out),
        .sample_strobe_in(sample_strobe_in),
        .accum_done_out(accum_done_out), .engine_enable_out(en_out),
        .equation_select_out(eqn_out), .equation_valid_out(valid_out),
        .element_mask_out(mask_out), .current_diff_out(cdiff_out),
        .accumulation_count_out(acc_out), .mux_divider_out(mux_out),
        .filter_length_out(fir_out), .timing_ok_out(timing_ok_out),
        .differential_enable_out(diff_out),
        .remote_sensor_enable_out(rmt_out),
        .engine_code_location_out(loc_out), .trim_page_select_out(trim_out)
    );
    tpcs_flash_model flash (.addr_in(prog_addr_in),
        .rdata_out(flash_rdata_in));

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    task end_of_test;
        if (mismatches == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    function automatic logic [7:0] fexp(input logic [16:0] a);
        return a[7:0] ^ a[15:8] ^ {7'h0, a[16]} ^ 8'h3c;
    endfunction : fexp

    function automatic logic [2:0] emask(input int c);
        case (c)
            2, 4: return 3'b011;
            3: return 3'b101;
            5: return 3'b111;
            default: return 3'b000;
        endcase
    endfunction : emask

    task io_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        io_addr_in <= a;
        io_wdata_in <= d;
        io_wr_in <= 1'b1;
        @(posedge clk_in);
        io_wr_in <= 1'b0;
        #1;
    endtask : io_write

    task io_read(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_in);
        io_addr_in <= a;
        io_rd_in <= 1'b1;
        @(posedge clk_in);
        io_rd_in <= 1'b0;
        #1;
        d = io_rdata_out;
    endtask : io_read

    task prog_rd(input logic [16:0] a, output logic [7:0] d);
        @(posedge clk_in);
        prog_addr_in <= a;
        prog_rd_in <= 1'b1;
        @(posedge clk_in);
        prog_rd_in <= 1'b0;
        #1;
        d = prog_rdata_out;
        chk(prog_rvalid_out, 1);
    endtask : prog_rd

    task eng_read(input logic [7:0] w, input logic [31:0] e);
        @(posedge clk_in);
        eng_word_addr_in <= w;
        @(posedge clk_in);
        #1;
        chk(eng_rdata_out, e);
    endtask : eng_read

    // disable first so each case starts from a cleared sample counter
    task acc_case(input logic [12:0] c, input int ns, input logic en,
        input logic e);
        io_write(`TPCS_IO_EQN, 8'ha0);
        io_write(`TPCS_IO_ACC_HI, {3'h0, c[12:8]});
        io_write(`TPCS_IO_ACC_LO, c[7:0]);
        io_write(`TPCS_IO_EQN, {7'h50, en});
        chk(en_out, en);
        @(posedge clk_in);
        sample_strobe_in <= 1'b1;
        repeat (ns) @(posedge clk_in);
        sample_strobe_in <= 1'b0;
        #1;
        chk(accum_done_out, e);
        @(posedge clk_in);
        #1;
        chk(accum_done_out, 0);
    endtask : acc_case

    initial begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        end_of_test();
    end

    initial begin
        {io_wr_in, io_rd_in, prog_rd_in, sample_strobe_in} = 4'h0;
        {io_addr_in, io_wdata_in, prog_addr_in} = '0;
        // word 2 is watched while its top byte is written below
        eng_word_addr_in = 8'h02;
        reset_n_in = 1'b0;
        mismatches = 0;
        n_checks = 0;
        tb = '{{5'h0, T_HOT[10:8]}, T_HOT[7:0], V_HOT[15:8], V_HOT[7:0],
            8'hc4, 8'h81, 8'h7e};
        repeat (16) @(posedge clk_in);
        reset_n_in <= 1'b1;
        #1;
        chk(mux_out, 7);
        chk(fir_out, 2'b01);
        chk(timing_ok_out, 1);
        chk(trim_out, 0);
        for (int i = 0; i < 8; i++) begin
            io_write(`TPCS_IO_EQN, {3'(i), 5'h0});
            chk(eqn_out, i);
            chk(valid_out, i >= 2 && i <= 5);
            chk(mask_out, emask(i));
            chk(cdiff_out, i == 3 || i == 4);
            chk(en_out, 0);
        end
        io_write(`TPCS_IO_MUX, 8'h60);
        chk(timing_ok_out, 0);
        io_read(`TPCS_IO_MUX, rd);
        chk(rd, 8'h60);
        io_write(`TPCS_IO_MUX, 8'he0);
        io_write(`TPCS_IO_DIFF, 8'h00);
        chk(timing_ok_out, 1);
        io_write(`TPCS_IO_DIFF, 8'h5b);
        chk(diff_out, 8'h5b);
        chk(fir_out, 2'b01);
        chk(timing_ok_out, 0);
        io_write(`TPCS_IO_RMT, 8'ha5);
        chk(rmt_out, 8'ha5);
        io_write(`TPCS_IO_ACC_HI, 8'hfa);
        io_write(`TPCS_IO_ACC_LO, 8'hbc);
        chk(acc_out, 13'h1abc);
        for (int i = 0; i < 4; i++) begin
            io_write(16'(16'h0008 + i), 8'(8'h12 + 8'h22 * i));
            io_write(16'(16'h03fc + i), 8'hff);
        end
        eng_read(8'd2, 32'h12345678);
        eng_read(8'd255, 32'hffffffff);
        io_read(16'h000a, rd);
        chk(rd, 8'h56);
        io_write(16'h1000, 8'h55);
        io_read(16'h1000, rd);
        chk(rd, 8'h00);
        io_write(`TPCS_IO_LOC, 8'h43);
        chk(loc_out, 7'h03);
        prog_rd(17'h00c94, rd);
        chk(rd, fexp(17'h00c94));
        io_write(`TPCS_IO_TRIM, 8'h01);
        chk(trim_out, 1);
        for (int i = 0; i < 7; i++) begin
            prog_rd(17'(17'h00c90 + i), got[i]);
            chk(got[i], tb[i]);
        end
        chk({{5{got[0][2]}}, got[0][2:0], got[1]}, 16'hfda3);
        chk({got[2], got[3]}, V_HOT);
        prog_rd(17'h00c97, rd);
        chk(rd, 8'h00);
        prog_rd(17'h10c94, rd);
        chk(rd, fexp(17'h10c94));
        prog_rd(17'h00894, rd);
        chk(rd, fexp(17'h00894));
        io_write(`TPCS_IO_TRIM, 8'h00);
        prog_rd(17'h00c94, rd);
        chk(rd, fexp(17'h00c94));
        acc_case(13'd2, 2, 1'b1, 1'b1);
        acc_case(13'd3, 2, 1'b1, 1'b0);
        acc_case(13'd1, 1, 1'b1, 1'b1);
        acc_case(13'd0, 3, 1'b1, 1'b0);
        acc_case(13'd2, 3, 1'b0, 1'b0);
        // mid-run reset must bring back the default frame timing
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        #1;
        chk({mux_out, fir_out, timing_ok_out}, {4'h7, 2'b01, 1'b1});
        chk({loc_out, trim_out, en_out, io_rdata_out}, 17'h00000);
        chk(acc_out, `TPCS_ACC_RST);
        end_of_test();
    end
endmodule : tpcs_top_test
